// File: rtl/pfsa_cfg.svh
// constants for the parallel signature and fuse access block
`ifndef PFSA_CFG_SVH
`define PFSA_CFG_SVH
// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define PFSA_CLK_MHZ 40
`define PFSA_BLT_US 150
`define PFSA_ROW_MS 2
`define PFSA_FUSE_MS 4
`define PFSA_BUSY_US 256
`define PFSA_VFY_NS 250
// ----------------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------------
`define PFSA_ROW_BYTES 32
`define PFSA_PAGES_2K 7'h3f
`define PFSA_PAGES_4K 7'h7f
`define PFSA_PAGE_USER 7'h00
`define PFSA_PAGE_FACTORY 7'h01
// ----------------------------------------------------------------------------
// fuse and lock fields, factory row bytes
// ----------------------------------------------------------------------------
`define PFSA_FUSE_UROW 2
`define PFSA_FUSE_RST 4'h0
`define PFSA_LOCK_RST 2'h3
`define PFSA_FACTORY_ID0 8'h5a // arbitrary value
`define PFSA_FACTORY_ID1 8'ha5 // arbitrary value
`define PFSA_FACTORY_FILL 8'hff
// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PFSA_CTRL_OFS 8'h00
`define PFSA_STAT_OFS 8'h04
`define PFSA_ADDR_OFS 8'h08
`define PFSA_MASK_OFS 8'h0c
`define PFSA_CTRL_RST 1'h1
`endif

// File: rtl/pfsa_pkg.sv
// types shared by the parallel signature and fuse access block
package pfsa_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_ROW  = 4'b0100,
        ST_FUSE = 4'b1000
    } pfsa_state_type;

    typedef enum logic [3:0] {
        MODE_ROW_WR  = 4'h0,
        MODE_FUSE_RD = 4'h3,
        MODE_ROW_RD  = 4'h8,
        MODE_PAGE    = 4'hd,
        MODE_FUSE_WR = 4'hf
    } pfsa_mode_type;
endpackage

// File: rtl/pfsa_pin_if.sv
// synchronised pin levels and edges between the pin stage and the core
`timescale 1ns/1ps
interface pfsa_pin_if #(parameter int W = 1);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// File: rtl/pfsa_pin_sync.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module pfsa_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pins,
    pfsa_pin_if.src sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stab_q;
    logic [W-1:0] prev_q;

    // meta_q feeds only stab_q; edges look at the later stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            stab_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pins;
            stab_q <= meta_q;
            prev_q <= stab_q;
        end
    end

    // level and one-cycle edge pulses
    assign sync.level = stab_q;
    assign sync.rise = stab_q & ~prev_q;
    assign sync.fall = ~stab_q & prev_q;
endmodule // pfsa_pin_sync

// File: rtl/pfsa_top.sv
// parallel programming access to the signature rows, fuses and lock bits
`timescale 1ns/1ps
`include "pfsa_cfg.svh"
// Contract
// - row write takes one to thirty-two bytes
// - strobe low captures data at offset
// - oscillator rise advances offset, skipping bytes
// - row programming lasts about 2ms
// - row write ignored when fuse disabled
// - code 1000 page 0 reads user row
// - code 1000 page 1 reads factory row
// - read offset advances on oscillator fall
// - code 1111 writes fuses and locks
// - fuse write lasts about 4ms
// - code 0011 reads fuses and locks
// - read data valid within 0.25us
// - busy low within 256us of expiry
// - user row plus read-only factory row
// - 2K or 4K flash, 64/128 pages
// - page load latches page, clears offset
// - page forms bits 11:5, offset 4:0
// - zero locked/enabled, one unlocked/disabled
module pfsa_top #(
    parameter int unsigned BLT_CYC = `PFSA_BLT_US * `PFSA_CLK_MHZ,
    parameter int unsigned ROW_CYC = `PFSA_ROW_MS * 1000 * `PFSA_CLK_MHZ,
    parameter int unsigned FUSE_CYC = `PFSA_FUSE_MS * 1000 * `PFSA_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic program_strobe_pin,
    input wire logic oscillator_input_pin,
    input wire logic mode_select_bit0,
    input wire logic mode_select_bit1,
    input wire logic mode_select_bit2,
    input wire logic mode_select_bit3,
    input wire logic [7:0] program_data_port_in,
    output logic [7:0] program_data_port_out,
    output logic program_data_port_oe,
    output logic ready_busy_output
);
    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    pfsa_pin_if #(.W(2)) ctl_if ();
    pfsa_pin_if #(.W(12)) dat_if ();

    pfsa_pin_sync #(.W(2)) u_ctl_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pins({oscillator_input_pin, program_strobe_pin}),
        .sync(ctl_if.src)
    );

    pfsa_pin_sync #(.W(12)) u_dat_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pins({mode_select_bit3, mode_select_bit2, mode_select_bit1, mode_select_bit0,
               program_data_port_in}),
        .sync(dat_if.src)
    );

    logic strobe_low;
    logic strobe_fall;
    logic osc_rise;
    logic osc_fall;
    logic [3:0] mode;
    logic [7:0] din;

    // mode is sampled at each edge; it must hold steady around the pulse
    assign strobe_low = ~ctl_if.level[0];
    assign strobe_fall = ctl_if.fall[0];
    assign osc_rise = ctl_if.rise[1];
    assign osc_fall = ctl_if.fall[1];
    assign mode = dat_if.level[11:8];
    assign din = dat_if.level[7:0];

    // ------------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------------
    pfsa_pkg::pfsa_state_type state_q;
    logic [17:0] timer_q;
    logic [6:0] page_q;
    logic [4:0] offset_q;
    logic [7:0] wbuf_q [`PFSA_ROW_BYTES];
    logic [31:0] wmask_q;
    logic [7:0] user_row_q [`PFSA_ROW_BYTES];
    logic [3:0] fuse_q;
    logic [1:0] lock_q;
    logic [5:0] fuse_new_q;
    logic [7:0] dout_q;
    logic oe_q;
    logic variant_4k_q;
    logic idle;
    logic loading;
    logic row_wr_ok;
    logic accept_byte;
    logic [6:0] page_mask;
    logic [7:0] read_byte;

    assign idle = (state_q == pfsa_pkg::ST_IDLE);
    assign loading = (state_q == pfsa_pkg::ST_LOAD);
    // row write needs page zero and the user row fuse enabled (zero)
    assign row_wr_ok = (mode == pfsa_pkg::MODE_ROW_WR) && (page_q == `PFSA_PAGE_USER)
                       && !fuse_q[`PFSA_FUSE_UROW];
    assign accept_byte = strobe_fall && row_wr_ok && (idle || loading);
    assign page_mask = variant_4k_q ? `PFSA_PAGES_4K : `PFSA_PAGES_2K;

    // factory row: two arbitrary identity bytes, the rest filled
    function automatic logic [7:0] factory_byte(input logic [4:0] ofs);
        case (ofs)
            5'h00: factory_byte = `PFSA_FACTORY_ID0; // arbitrary value
            5'h01: factory_byte = `PFSA_FACTORY_ID1; // arbitrary value
            default: factory_byte = `PFSA_FACTORY_FILL;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // page register and byte offset
    // ------------------------------------------------------------------------
    // write offset steps on the oscillator rise, read offset on its fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= 7'h00;
            offset_q <= 5'h00;
        end else if (osc_fall && idle && mode == pfsa_pkg::MODE_PAGE) begin
            page_q <= din[6:0] & page_mask;
            offset_q <= 5'h00;
        end else if (osc_rise && (idle || loading) && mode == pfsa_pkg::MODE_ROW_WR) begin
            offset_q <= offset_q + 5'h01;
        end else if (osc_fall && idle && mode == pfsa_pkg::MODE_ROW_RD) begin
            offset_q <= offset_q + 5'h01;
        end
    end

    // ------------------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------------------
    // each strobe stores one byte; skipped offsets stay unmarked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wmask_q <= 32'h0000_0000;
            for (int i = 0; i < `PFSA_ROW_BYTES; i++) begin
                wbuf_q[i] <= 8'h00;
            end
        end else if (accept_byte) begin
            wbuf_q[offset_q] <= din;
            wmask_q[offset_q] <= 1'b1;
        end else if (state_q == pfsa_pkg::ST_ROW && timer_q == 18'h0) begin
            wmask_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // sequencer and interval timer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pfsa_pkg::ST_IDLE;
            timer_q <= 18'h0;
            fuse_new_q <= 6'h00;
        end else begin
            unique case (state_q)
                pfsa_pkg::ST_IDLE: begin
                    if (accept_byte) begin
                        state_q <= pfsa_pkg::ST_LOAD;
                        timer_q <= 18'(BLT_CYC - 1);
                    end else if (strobe_fall && mode == pfsa_pkg::MODE_FUSE_WR) begin
                        state_q <= pfsa_pkg::ST_FUSE;
                        timer_q <= 18'(FUSE_CYC - 1);
                        fuse_new_q <= {din[7:4], din[1:0]};
                    end
                end
                pfsa_pkg::ST_LOAD: begin
                    if (strobe_low) begin
                        timer_q <= 18'(BLT_CYC - 1);
                    end else if (timer_q == 18'h0) begin
                        state_q <= pfsa_pkg::ST_ROW;
                        timer_q <= 18'(ROW_CYC - 1);
                    end else begin
                        timer_q <= timer_q - 18'h1;
                    end
                end
                pfsa_pkg::ST_ROW, pfsa_pkg::ST_FUSE: begin
                    if (timer_q == 18'h0) begin
                        state_q <= pfsa_pkg::ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 18'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // nonvolatile contents
    // ------------------------------------------------------------------------
    // the user row takes the marked bytes at the end of its interval
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PFSA_ROW_BYTES; i++) begin
                user_row_q[i] <= 8'hff;
            end
        end else if (state_q == pfsa_pkg::ST_ROW && timer_q == 18'h0) begin
            for (int i = 0; i < `PFSA_ROW_BYTES; i++) begin
                if (wmask_q[i]) begin
                    user_row_q[i] <= wbuf_q[i];
                end
            end
        end
    end

    // fuses and locks keep the pin polarity: zero enabled or locked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_q <= `PFSA_FUSE_RST;
            lock_q <= `PFSA_LOCK_RST;
        end else if (state_q == pfsa_pkg::ST_FUSE && timer_q == 18'h0) begin
            fuse_q <= fuse_new_q[5:2];
            lock_q <= fuse_new_q[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // data port and busy pin
    // ------------------------------------------------------------------------
    always_comb begin
        read_byte = `PFSA_FACTORY_FILL;
        if (mode == pfsa_pkg::MODE_FUSE_RD) begin
            read_byte = {fuse_q, 2'b00, lock_q};
        end else if (page_q == `PFSA_PAGE_USER) begin
            read_byte = user_row_q[offset_q];
        end else if (page_q == `PFSA_PAGE_FACTORY) begin
            read_byte = factory_byte(offset_q);
        end
    end

    // drive the port in read modes only while the sequencer is idle (no load, row or fuse interval)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            dout_q <= read_byte;
            oe_q <= idle && (mode == pfsa_pkg::MODE_ROW_RD || mode == pfsa_pkg::MODE_FUSE_RD);
        end
    end

    assign program_data_port_out = dout_q;
    assign program_data_port_oe = oe_q;
    assign ready_busy_output = ~(state_q == pfsa_pkg::ST_ROW || state_q == pfsa_pkg::ST_FUSE);

    // ------------------------------------------------------------------------
    // ahb-lite register slave
    // ------------------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] waddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            `PFSA_CTRL_OFS: rd_mux = {31'h0, variant_4k_q};
            `PFSA_STAT_OFS: rd_mux = {18'h0, lock_q, fuse_q, 3'h0, ready_busy_output, state_q};
            `PFSA_ADDR_OFS: rd_mux = {20'h0, page_q, offset_q};
            `PFSA_MASK_OFS: rd_mux = wmask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // address phase: latch write target, prepare read word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            waddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            waddr_q <= haddr[7:0];
            hrdata_q <= (hsel && htrans[1] && !hwrite) ? rd_mux : 32'h0000_0000;
        end
    end
    // data phase: control register write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            variant_4k_q <= `PFSA_CTRL_RST;
        end else if (wr_pend_q && waddr_q == `PFSA_CTRL_OFS) begin
            variant_4k_q <= hwdata[0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        accept_byte |=> wbuf_q[$past(offset_q)] == $past(din) && wmask_q[$past(offset_q)];
    endproperty
    a_capture: assert property (p_capture) else $error("byte not captured");
    property p_advance;
        @(posedge clk) disable iff (!rst_n)
        osc_rise && loading && mode == pfsa_pkg::MODE_ROW_WR |=> offset_q == $past(offset_q) + 5'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("offset did not advance");
    property p_fuse_block;
        @(posedge clk) disable iff (!rst_n)
        idle && strobe_fall && mode == pfsa_pkg::MODE_ROW_WR && fuse_q[`PFSA_FUSE_UROW]
        |=> idle && wmask_q == $past(wmask_q);
    endproperty
    a_fuse_block: assert property (p_fuse_block) else $error("row write not blocked");
    property p_read_step;
        @(posedge clk) disable iff (!rst_n)
        osc_fall && idle && mode == pfsa_pkg::MODE_ROW_RD
        |=> offset_q == $past(offset_q) + 5'h01 ##1 dout_q == $past(read_byte);
    endproperty
    a_read_step: assert property (p_read_step) else $error("read step late");
    property p_factory;
        @(posedge clk) disable iff (!rst_n)
        mode == pfsa_pkg::MODE_ROW_RD && page_q == `PFSA_PAGE_FACTORY
        |=> dout_q == factory_byte($past(offset_q));
    endproperty
    a_factory: assert property (p_factory) else $error("factory byte wrong");
    property p_fuse_read;
        @(posedge clk) disable iff (!rst_n)
        mode == pfsa_pkg::MODE_FUSE_RD ##1 mode == pfsa_pkg::MODE_FUSE_RD
        |-> dout_q == {$past(fuse_q), 2'b00, $past(lock_q)};
    endproperty
    a_fuse_read: assert property (p_fuse_read) else $error("fuse read wrong");
    property p_page_load;
        @(posedge clk) disable iff (!rst_n)
        osc_fall && idle && mode == pfsa_pkg::MODE_PAGE
        |=> offset_q == 5'h00 && page_q == ($past(din[6:0]) & $past(page_mask));
    endproperty
    a_page_load: assert property (p_page_load) else $error("page load wrong");
    property p_busy_start;
        @(posedge clk) disable iff (!rst_n)
        loading && !strobe_low && timer_q == 18'h0 |=> !ready_busy_output && timer_q == 18'(ROW_CYC - 1);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");
    property p_fuse_time;
        @(posedge clk) disable iff (!rst_n)
        idle && strobe_fall && mode == pfsa_pkg::MODE_FUSE_WR
        |=> state_q == pfsa_pkg::ST_FUSE && timer_q == 18'(FUSE_CYC - 1) && !ready_busy_output;
    endproperty
    a_fuse_time: assert property (p_fuse_time) else $error("fuse write not started");
    property p_ready_back;
        @(posedge clk) disable iff (!rst_n)
        !ready_busy_output && timer_q == 18'h0 |=> ready_busy_output ##0 idle;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored");
endmodule // pfsa_top

// File: dv/pfsa_program_strobe.sv
// programmer model that drives the parallel programming pins
`timescale 1ns/1ps
module pfsa_program_strobe (
    input wire logic clk,
    output logic strobe,
    output logic osc,
    output logic [3:0] mode,
    output logic [7:0] data,
    output logic drv
);
    // pins idle: strobe high, oscillator low, port released
    initial begin
        strobe = 1'b1;
        osc = 1'b0;
        mode = 4'h5;
        data = 8'h00;
        drv = 1'b0;
    end

    // new code held steady before and around every pulse
    task automatic set_mode(input logic [3:0] m);
        @(posedge clk);
        mode <= m;
        repeat (6) @(posedge clk);
    endtask

    // positive oscillator pulse, two cycles high and two low
    task automatic osc_pulse();
        @(posedge clk);
        osc <= 1'b1;
        repeat (2) @(posedge clk);
        osc <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // byte driven around a strobe low pulse, then the port released
    task automatic write_byte(input logic [7:0] d);
        @(posedge clk);
        data <= d;
        drv <= 1'b1;
        repeat (2) @(posedge clk);
        strobe <= 1'b0;
        repeat (4) @(posedge clk);
        strobe <= 1'b1;
        repeat (2) @(posedge clk);
        drv <= 1'b0;
    endtask

    // page number latched on the oscillator fall, data held past it
    task automatic load_page(input logic [7:0] p);
        set_mode(pfsa_pkg::MODE_PAGE);
        @(posedge clk);
        data <= p;
        drv <= 1'b1;
        osc_pulse();
        repeat (2) @(posedge clk);
        drv <= 1'b0;
    endtask
endmodule // pfsa_program_strobe

// File: dv/parallel_flash_signature_fuse_access_bench.sv
// self-checking bench for the parallel signature and fuse access block
`timescale 1ns/1ps
`include "pfsa_cfg.svh"
module parallel_flash_signature_fuse_access_bench;
    localparam int ROW = 50;
    localparam int FUSE = 60;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, strobe, osc, drv, oe, ready, wr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, lk;
    logic [2:0] hsize;
    logic [3:0] mode, fz;
    logic [7:0] pdata, pout, port, b;
    logic [7:0] row [32];
    int errors = 0;
    int n_tests = 0;
    int run = 0;
    int last = 0;
    int k;

    // pulled-up port: device, then programmer, else all ones
    assign port = oe ? pout : (drv ? pdata : 8'hff);

    pfsa_program_strobe program_strobe (.clk(clk), .strobe(strobe), .osc(osc), .mode(mode), .data(pdata),
        .drv(drv));
    pfsa_top #(.BLT_CYC(20), .ROW_CYC(ROW), .FUSE_CYC(FUSE)) dut (.clk(clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .program_strobe_pin(strobe),
        .oscillator_input_pin(osc), .mode_select_bit0(mode[0]),
        .mode_select_bit1(mode[1]), .mode_select_bit2(mode[2]),
        .mode_select_bit3(mode[3]), .program_data_port_in(port),
        .program_data_port_out(pout), .program_data_port_oe(oe),
        .ready_busy_output(ready));

    // clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // length of the latest busy interval in clock cycles
    always @(posedge clk) begin
        if (ready === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            last <= run;
            run <= 0;
        end
    end

    function automatic logic [7:0] exp_byte(input logic [7:0] pg, input int i);
        if (pg == 8'h00) return row[i];
        if (i == 0) return `PFSA_FACTORY_ID0;
        return (i == 1) ? `PFSA_FACTORY_ID1 : `PFSA_FACTORY_FILL;
    endfunction

    function automatic logic [31:0] stat_exp(input logic [3:0] f, input logic [1:0] l);
        return {18'h0, l, f, 3'h0, 1'b1, 4'h1};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single AHB-Lite transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string what);
        ahb(1'b0, a, 32'h0);
        chk(what, rd, e);
        chk("response", {hreadyout, hresp}, 2'b10);
    endtask

    // busy must start soon after loading and end within a bound
    task automatic wait_ready();
        k = 0;
        while (ready !== 1'b0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk("busy start", k < 40, 1'b1);
        while (ready !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk("busy end", k < 2000, 1'b1);
        repeat (2) @(negedge clk);
    endtask

    // read n bytes of a row, stepping on each oscillator fall
    task automatic read_row(input logic [7:0] pg, input int n);
        program_strobe.load_page(pg);
        program_strobe.set_mode(pfsa_pkg::MODE_ROW_RD);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            chk("read byte", port, exp_byte(pg, i));
            program_strobe.osc_pulse();
            repeat (5) @(posedge clk);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        rd = $urandom(61);
        for (int i = 0; i < 32; i++) row[i] = 8'hff;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("idle ready", {ready, oe}, 2'b10);
        rchk(`PFSA_STAT_OFS, stat_exp(`PFSA_FUSE_RST, `PFSA_LOCK_RST), "status");
        ahb(1'b1, `PFSA_STAT_OFS, 32'h0);
        rchk(`PFSA_STAT_OFS, stat_exp(`PFSA_FUSE_RST, `PFSA_LOCK_RST), "status ro");
        rchk(32'h10, 32'h0, "unmapped");
        rchk(`PFSA_CTRL_OFS, 32'h1, "ctrl");
        // random bytes with single skips across the whole row
        program_strobe.load_page(8'h00);
        program_strobe.set_mode(pfsa_pkg::MODE_ROW_WR);
        wr = 1'b1;
        for (int i = 0; i < 32; i++) begin
            b = $urandom;
            if (wr) program_strobe.write_byte(b);
            if (wr) row[i] = b;
            wr = !wr || ($urandom % 2 == 0);
            program_strobe.osc_pulse();
        end
        wait_ready();
        chk("row busy", last, ROW);
        read_row(8'h00, 32);
        read_row(8'h01, 3);
        program_strobe.load_page(8'hc5);
        rchk(`PFSA_ADDR_OFS, 32'h8a0, "addr 4k");
        ahb(1'b1, `PFSA_CTRL_OFS, 32'h0);
        program_strobe.load_page(8'hc5);
        rchk(`PFSA_ADDR_OFS, 32'h0a0, "addr 2k");
        ahb(1'b1, `PFSA_CTRL_OFS, 32'h1);
        // fuses with the row write disabled, random locks
        fz = $urandom;
        fz[`PFSA_FUSE_UROW] = 1'b1;
        lk = $urandom;
        program_strobe.set_mode(pfsa_pkg::MODE_FUSE_WR);
        program_strobe.write_byte({fz, 2'b11, lk});
        wait_ready();
        chk("fuse busy", last, FUSE);
        rchk(`PFSA_STAT_OFS, stat_exp(fz, lk), "status fuse");
        program_strobe.set_mode(pfsa_pkg::MODE_FUSE_RD);
        @(negedge clk);
        chk("fuse read", port, {fz, 2'b00, lk});
        // row write must now be ignored
        program_strobe.load_page(8'h00);
        program_strobe.set_mode(pfsa_pkg::MODE_ROW_WR);
        program_strobe.write_byte(~row[0]);
        repeat (40) @(negedge clk);
        chk("no busy run", run, 32'h0);
        chk("no busy last", last, FUSE);
        rchk(`PFSA_MASK_OFS, 32'h0, "mask empty");
        read_row(8'h00, 1);
        give_verdict();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule // parallel_flash_signature_fuse_access_bench
